//--- inc/pmv_defines.svh
`ifndef PMV_DEFINES_SVH
`define PMV_DEFINES_SVH

// Vector table geometry
`define PMV_VEC_COUNT 32
`define PMV_VEC_TOP_ADDR 16'hFFFE
`define PMV_VEC_LOW_ADDR 16'hFFC0
`define PMV_VEC_UNUSED 5'h1F

// Vector numbers of the wired sources and the two empty vectors
`define PMV_VEC_MOD_TIMER 5'h1A
`define PMV_VEC_REALTIME 5'h19
`define PMV_VEC_TWO_WIRE 5'h18
`define PMV_VEC_CONVERTER 5'h17
`define PMV_VEC_NONE_22 5'h16
`define PMV_VEC_PORT_B 5'h15
`define PMV_VEC_PORT_A 5'h14
`define PMV_VEC_NONE_19 5'h13
`define PMV_VEC_SER_TX 5'h12
`define PMV_VEC_SER_RX 5'h11
`define PMV_VEC_SER_ERR 5'h10
`define PMV_VEC_SPI 5'h0F
`define PMV_VEC_PWM2_OVF 5'h0E
`define PMV_VEC_PWM2_CH1 5'h0D

// Reset values
`define PMV_RST_VEC_NUM 5'h00
`define PMV_RST_VEC_ADDR 16'hFFFE

`endif

//--- inc/pmv_pkg.sv
package pmv_pkg;

    typedef enum logic [1:0] {
        PMV_MODE_RUN,
        PMV_MODE_BGND,
        PMV_MODE_WAIT,
        PMV_MODE_STOP
    } pmv_mode_e;

    typedef enum logic [2:0] {
        PMV_CMD_MEM,
        PMV_CMD_MEM_STAT,
        PMV_CMD_DBG_REG,
        PMV_CMD_BACKGROUND,
        PMV_CMD_CPU_REG,
        PMV_CMD_TRACE,
        PMV_CMD_GO,
        PMV_CMD_RSVD
    } pmv_cmd_e;

    typedef logic [4:0] pmv_vec_t;
    typedef logic [15:0] pmv_addr_t;

endpackage

//--- inc/pmv_irq_if.sv
`timescale 1ns/1ps
interface pmv_irq_if;
    logic [31:0] req;
    logic pend;
    logic [4:0] vec_num;
    logic [15:0] vec_addr;

    modport ctrl (output req, input pend, vec_num, vec_addr);
    modport arb (input req, output pend, vec_num, vec_addr);
endinterface

//--- rtl/pmv_vector_arb.sv
`timescale 1ns/1ps
`include "pmv_defines.svh"
module pmv_vector_arb import pmv_pkg::*; (
    pmv_irq_if.arb irq // Vector requests in, winner out
);

    // Lowest vector number has the highest priority
    function automatic pmv_vec_t pick_vec(input logic [31:0] req);
        pmv_vec_t num;
        num = `PMV_VEC_UNUSED;
        for (int i = 31; i >= 0; i--) begin
            if (req[i]) begin
                num = 5'(i);
            end
        end
        return num;
    endfunction

    function automatic pmv_addr_t vec_addr(input pmv_vec_t num);
        return `PMV_VEC_TOP_ADDR - {10'h000, num, 1'b0};
    endfunction

    always_comb begin
        irq.pend = |irq.req;
        irq.vec_num = pick_vec(irq.req);
        irq.vec_addr = vec_addr(irq.vec_num);
    end

endmodule // pmv_vector_arb

//--- rtl/pmv_top.sv
`timescale 1ns/1ps
`include "pmv_defines.svh"
// Overview of operation
// - Non-intrusive debug commands work in run, background
// - CPU register, trace, go only in background
// - Wait instruction stops the CPU clock
// - Entering wait clears the interrupt mask
// - Interrupt ends wait, starting the stacking sequence
// - Wait accepts only background and status-memory commands
// - Status-memory in wait/stop: no access, error status
// - Background command wakes wait into background mode
// - Stop instruction enters stop only if allowed
// - Stop halts bus and CPU clocks
// - Reference clocks may keep running in stop
// - Two-byte vector pairs, vector 31 lowest, unused
// - Modulo timer overflow requests vector 26
// - Real-time counter requests vector 25
// - Two-wire module requests vector 24
// - Converter requests 23; vectors 22, 19 empty
// - Port B requests 21, port A 20
// - Serial transmit sources request vector 18
// - Serial receive sources request vector 17
// - Serial error sources request vector 16
// - SPI sources request vector 15
// - Second PWM timer: overflow 14, channel 13
// - Lower vector number wins; reset vector highest
module pmv_top import pmv_pkg::*; (
    input wire logic core_clk, // 50 MHz core clock
    input wire logic rst_n, // Async reset, active low
    input wire logic debug_mode_pin, // Debug pin level, low selects background at reset
    input wire logic wait_exec, // CPU executed wait, one-cycle pulse
    input wire logic stop_exec, // CPU executed stop, one-cycle pulse
    input wire logic halt_allow_bit, // Stop permitted, from system options
    input wire logic stop_deep_sel, // Selects the deeper of the two stop modes
    input wire logic ref_keep_cfg, // Clock generator keeps reference in stop
    input wire logic dbg_cmd_valid, // Decoded debug command strobe
    input wire logic [2:0] dbg_cmd, // Debug command code
    input wire logic count_overflow_flag, // Modulo timer
    input wire logic count_overflow_irq_en, // Modulo timer
    input wire logic realtime_irq_flag, // Real-time counter
    input wire logic realtime_irq_en, // Real-time counter
    input wire logic two_wire_irq_flag, // Two-wire module
    input wire logic two_wire_irq_en, // Two-wire module
    input wire logic conversion_done_flag, // Converter
    input wire logic converter_irq_en, // Converter
    input wire logic port_b_pin_irq_flag, // Port B pins
    input wire logic port_b_pin_irq_en, // Port B pins
    input wire logic port_a_pin_irq_flag, // Port A pins
    input wire logic port_a_pin_irq_en, // Port A pins
    input wire logic tx_buffer_empty_flag, // Serial port
    input wire logic tx_buffer_empty_irq_en, // Serial port
    input wire logic transmit_complete_flag, // Serial port
    input wire logic transmit_complete_irq_en, // Serial port
    input wire logic quiet_line_flag, // Serial port idle line
    input wire logic quiet_line_irq_en, // Serial port idle line
    input wire logic rx_full_flag, // Serial port
    input wire logic rx_full_irq_en, // Serial port
    input wire logic break_detect_flag, // Serial port
    input wire logic break_detect_irq_en, // Serial port
    input wire logic rx_pin_edge_flag, // Serial port
    input wire logic rx_pin_edge_irq_en, // Serial port
    input wire logic overrun_flag, // Serial port
    input wire logic overrun_irq_en, // Serial port
    input wire logic noise_flag, // Serial port
    input wire logic noise_irq_en, // Serial port
    input wire logic framing_err_flag, // Serial port
    input wire logic framing_err_irq_en, // Serial port
    input wire logic parity_err_flag, // Serial port
    input wire logic parity_err_irq_en, // Serial port
    input wire logic serial_transfer_done_flag, // SPI
    input wire logic mode_fault_flag, // SPI
    input wire logic serial_rx_irq_en, // SPI, shared by done and fault
    input wire logic serial_tx_empty_flag, // SPI
    input wire logic serial_tx_empty_irq_en, // SPI
    input wire logic pwm2_overflow_flag, // Second PWM timer
    input wire logic pwm2_overflow_irq_en, // Second PWM timer
    input wire logic channel_one_event_flag, // Second PWM timer
    input wire logic channel_one_irq_en, // Second PWM timer
    output logic [1:0] mode_q, // Current mode, pmv_mode_e coding
    output logic cpu_clk_en_q, // CPU clock gate enable
    output logic bus_clk_en_q, // Bus clock gate enable
    output logic ref_clk_run_q, // Reference clocks enabled
    output logic stop_deep_q, // Deep stop selected while in stop
    output logic imask_clear_q, // Clear interrupt mask, pulse
    output logic stack_start_q, // Start interrupt stacking, pulse
    output logic stop_refused_q, // Stop executed while not allowed, pulse
    output logic irq_pend_q, // Some vector pending
    output logic [4:0] irq_vec_num_q, // Winning vector number
    output logic [15:0] irq_vec_addr_q, // Winning vector high-byte address
    output logic dbg_exec_q, // Debug command executed, pulse
    output logic dbg_mem_en_q, // Debug memory access performed, pulse
    output logic dbg_err_q, // Status reports stop or wait, pulse
    output logic dbg_ignore_q, // Debug command ignored, pulse
    output logic trace_step_q // Trace one instruction, pulse
);

    pmv_irq_if irq ();

    pmv_vector_arb u_arb (
        .irq(irq.arb)
    );

    // Vector request mapping
    always_comb begin
        irq.req = '0;
        irq.req[`PMV_VEC_MOD_TIMER] = count_overflow_flag & count_overflow_irq_en;
        irq.req[`PMV_VEC_REALTIME] = realtime_irq_flag & realtime_irq_en;
        irq.req[`PMV_VEC_TWO_WIRE] = two_wire_irq_flag & two_wire_irq_en;
        irq.req[`PMV_VEC_CONVERTER] = conversion_done_flag & converter_irq_en;
        irq.req[`PMV_VEC_NONE_22] = 1'b0;
        irq.req[`PMV_VEC_NONE_19] = 1'b0;
        irq.req[`PMV_VEC_UNUSED] = 1'b0;
        irq.req[`PMV_VEC_PORT_B] = port_b_pin_irq_flag & port_b_pin_irq_en;
        irq.req[`PMV_VEC_PORT_A] = port_a_pin_irq_flag & port_a_pin_irq_en;
        irq.req[`PMV_VEC_SER_TX] = (tx_buffer_empty_flag & tx_buffer_empty_irq_en)
            | (transmit_complete_flag & transmit_complete_irq_en);
        irq.req[`PMV_VEC_SER_RX] = (quiet_line_flag & quiet_line_irq_en)
            | (rx_full_flag & rx_full_irq_en)
            | (break_detect_flag & break_detect_irq_en)
            | (rx_pin_edge_flag & rx_pin_edge_irq_en);
        irq.req[`PMV_VEC_SER_ERR] = (overrun_flag & overrun_irq_en)
            | (noise_flag & noise_irq_en)
            | (framing_err_flag & framing_err_irq_en)
            | (parity_err_flag & parity_err_irq_en);
        irq.req[`PMV_VEC_SPI] = ((serial_transfer_done_flag | mode_fault_flag) & serial_rx_irq_en)
            | (serial_tx_empty_flag & serial_tx_empty_irq_en);
        irq.req[`PMV_VEC_PWM2_OVF] = pwm2_overflow_flag & pwm2_overflow_irq_en;
        irq.req[`PMV_VEC_PWM2_CH1] = channel_one_event_flag & channel_one_irq_en;
    end

    // Debug pin synchroniser and strap capture
    logic pin_meta_q, pin_sync_q, strap_done_q;
    logic strap_done_d;

    // No reset: strap level must already be live at the capture edge
    always_ff @(posedge core_clk) begin
        pin_meta_q <= debug_mode_pin;
        pin_sync_q <= pin_meta_q;
    end

    // Mode machine
    pmv_mode_e mode_s_q, mode_s_d;
    logic cpu_clk_en_d, bus_clk_en_d, ref_clk_run_d, stop_deep_d;
    logic imask_clear_d, stack_start_d, stop_refused_d;
    logic dbg_exec_d, dbg_mem_en_d, dbg_err_d, dbg_ignore_d, trace_step_d;
    logic stop_deep_s_q, stop_deep_s_d;
    logic strap_wait_q, strap_wait_d;
    pmv_cmd_e cmd;

    function automatic logic cmd_non_intrusive(input pmv_cmd_e c);
        return (c == PMV_CMD_MEM) || (c == PMV_CMD_MEM_STAT)
            || (c == PMV_CMD_DBG_REG) || (c == PMV_CMD_BACKGROUND);
    endfunction

    function automatic logic cmd_active_bgnd(input pmv_cmd_e c);
        return (c == PMV_CMD_CPU_REG) || (c == PMV_CMD_TRACE) || (c == PMV_CMD_GO);
    endfunction

    always_comb begin
        cmd = pmv_cmd_e'(dbg_cmd);
        mode_s_d = mode_s_q;
        stop_deep_s_d = stop_deep_s_q;
        strap_done_d = strap_done_q;
        strap_wait_d = strap_wait_q;
        imask_clear_d = 1'b0;
        stack_start_d = 1'b0;
        stop_refused_d = 1'b0;
        dbg_exec_d = 1'b0;
        dbg_mem_en_d = 1'b0;
        dbg_err_d = 1'b0;
        dbg_ignore_d = 1'b0;
        trace_step_d = 1'b0;
        // Pin sampled two edges after release, once synchroniser holds live data
        if (!strap_done_q) begin
            strap_wait_d = 1'b1;
            if (strap_wait_q) begin
                strap_done_d = 1'b1;
                if (!pin_sync_q) begin
                    mode_s_d = PMV_MODE_BGND;
                end
            end
        end else begin
            case (mode_s_q)
                PMV_MODE_RUN: begin
                    if (dbg_cmd_valid) begin
                        if (cmd_non_intrusive(cmd)) begin
                            dbg_exec_d = 1'b1;
                            dbg_mem_en_d = (cmd == PMV_CMD_MEM) || (cmd == PMV_CMD_MEM_STAT);
                            if (cmd == PMV_CMD_BACKGROUND) begin
                                mode_s_d = PMV_MODE_BGND;
                            end
                        end else begin
                            dbg_ignore_d = 1'b1;
                        end
                    end else if (wait_exec) begin
                        mode_s_d = PMV_MODE_WAIT;
                        imask_clear_d = 1'b1;
                    end else if (stop_exec) begin
                        if (halt_allow_bit) begin
                            mode_s_d = PMV_MODE_STOP;
                            stop_deep_s_d = stop_deep_sel;
                        end else begin
                            stop_refused_d = 1'b1;
                        end
                    end
                end
                PMV_MODE_BGND: begin
                    if (dbg_cmd_valid) begin
                        if (cmd_non_intrusive(cmd) || cmd_active_bgnd(cmd)) begin
                            dbg_exec_d = 1'b1;
                            dbg_mem_en_d = (cmd == PMV_CMD_MEM) || (cmd == PMV_CMD_MEM_STAT);
                            trace_step_d = (cmd == PMV_CMD_TRACE);
                            if (cmd == PMV_CMD_GO) begin
                                mode_s_d = PMV_MODE_RUN;
                            end
                        end else begin
                            dbg_ignore_d = 1'b1;
                        end
                    end
                end
                PMV_MODE_WAIT: begin
                    if (dbg_cmd_valid && cmd == PMV_CMD_BACKGROUND) begin
                        dbg_exec_d = 1'b1;
                        mode_s_d = PMV_MODE_BGND;
                    end else if (irq.pend) begin
                        mode_s_d = PMV_MODE_RUN;
                        stack_start_d = 1'b1;
                        dbg_ignore_d = dbg_cmd_valid && cmd != PMV_CMD_MEM_STAT;
                        dbg_err_d = dbg_cmd_valid && cmd == PMV_CMD_MEM_STAT;
                    end else if (dbg_cmd_valid) begin
                        if (cmd == PMV_CMD_MEM_STAT) begin
                            dbg_err_d = 1'b1;
                        end else begin
                            dbg_ignore_d = 1'b1;
                        end
                    end
                end
                PMV_MODE_STOP: begin
                    if (dbg_cmd_valid) begin
                        if (cmd == PMV_CMD_MEM_STAT) begin
                            dbg_err_d = 1'b1;
                        end else begin
                            dbg_ignore_d = 1'b1;
                        end
                    end
                    if (irq.pend) begin
                        mode_s_d = PMV_MODE_RUN;
                        stack_start_d = 1'b1;
                    end
                end
                default: begin
                    mode_s_d = PMV_MODE_RUN;
                end
            endcase
        end
        cpu_clk_en_d = (mode_s_d == PMV_MODE_RUN) || (mode_s_d == PMV_MODE_BGND);
        bus_clk_en_d = (mode_s_d != PMV_MODE_STOP);
        ref_clk_run_d = (mode_s_d != PMV_MODE_STOP) || ref_keep_cfg;
        stop_deep_d = (mode_s_d == PMV_MODE_STOP) && stop_deep_s_d;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_s_q <= PMV_MODE_RUN;
            stop_deep_s_q <= 1'b0;
            strap_done_q <= 1'b0;
            strap_wait_q <= 1'b0;
            mode_q <= 2'h0;
            cpu_clk_en_q <= 1'b1;
            bus_clk_en_q <= 1'b1;
            ref_clk_run_q <= 1'b1;
            stop_deep_q <= 1'b0;
            imask_clear_q <= 1'b0;
            stack_start_q <= 1'b0;
            stop_refused_q <= 1'b0;
            dbg_exec_q <= 1'b0;
            dbg_mem_en_q <= 1'b0;
            dbg_err_q <= 1'b0;
            dbg_ignore_q <= 1'b0;
            trace_step_q <= 1'b0;
        end else begin
            mode_s_q <= mode_s_d;
            stop_deep_s_q <= stop_deep_s_d;
            strap_done_q <= strap_done_d;
            strap_wait_q <= strap_wait_d;
            mode_q <= mode_s_d;
            cpu_clk_en_q <= cpu_clk_en_d;
            bus_clk_en_q <= bus_clk_en_d;
            ref_clk_run_q <= ref_clk_run_d;
            stop_deep_q <= stop_deep_d;
            imask_clear_q <= imask_clear_d;
            stack_start_q <= stack_start_d;
            stop_refused_q <= stop_refused_d;
            dbg_exec_q <= dbg_exec_d;
            dbg_mem_en_q <= dbg_mem_en_d;
            dbg_err_q <= dbg_err_d;
            dbg_ignore_q <= dbg_ignore_d;
            trace_step_q <= trace_step_d;
        end
    end

    // Vector dispatch registers
    logic irq_pend_d;
    pmv_vec_t irq_vec_num_d;
    pmv_addr_t irq_vec_addr_d;

    always_comb begin
        irq_pend_d = irq.pend;
        irq_vec_num_d = irq.vec_num;
        irq_vec_addr_d = irq.vec_addr;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_pend_q <= 1'b0;
            irq_vec_num_q <= `PMV_RST_VEC_NUM;
            irq_vec_addr_q <= `PMV_RST_VEC_ADDR;
        end else begin
            irq_pend_q <= irq_pend_d;
            irq_vec_num_q <= irq_vec_num_d;
            irq_vec_addr_q <= irq_vec_addr_d;
        end
    end

endmodule // pmv_top

//--- testbench/pmv_src_model.sv
`timescale 1ns/1ps
module pmv_src_model (
    input wire logic [4:0] src_sel, // First source index plus one, 0 none
    input wire logic [4:0] src_sel2, // Second source index plus one, 0 none
    input wire logic gate_on, // Enables match flags when high
    output logic [20:0] flags, // Peripheral flag levels
    output logic [20:0] enables // Peripheral enable levels
);
    always_comb begin
        flags = '0;
        if (src_sel != 5'h00) flags[src_sel - 5'h01] = 1'b1;
        if (src_sel2 != 5'h00) flags[src_sel2 - 5'h01] = 1'b1;
        // Gated off: every enable set except those of the raised flags
        enables = gate_on ? '1 : ~flags;
    end
endmodule // pmv_src_model

//--- testbench/pmv_checker.sv
`timescale 1ns/1ps
module pmv_checker (
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Reset, active low
    input wire logic wait_exec, // Wait pulse
    input wire logic stop_exec, // Stop pulse
    input wire logic halt_allow_bit, // Stop permitted
    input wire logic dbg_cmd_valid, // Command strobe
    input wire logic [2:0] dbg_cmd, // Command code
    input wire logic count_overflow_flag, // Timer flag
    input wire logic count_overflow_irq_en, // Timer enable
    input logic [1:0] mode_q, // Mode
    input logic cpu_clk_en_q, // CPU clock gate
    input logic bus_clk_en_q, // Bus clock gate
    input logic imask_clear_q, // Mask clear pulse
    input logic stop_refused_q, // Stop refused pulse
    input logic irq_pend_q, // Vector pending
    input logic [4:0] irq_vec_num_q, // Vector number
    input logic [15:0] irq_vec_addr_q, // Vector address
    input logic dbg_exec_q, // Command executed
    input logic dbg_mem_en_q, // Memory access done
    input logic dbg_err_q, // Status error
    input logic dbg_ignore_q // Command ignored
);
    logic [1:0] age_q;
    logic [1:0] age_d;
    logic ok;
    // Strap capture occupies the first two edges after reset
    always_comb begin
        age_d = (age_q == 2'h3) ? age_q : age_q + 2'h1;
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) age_q <= 2'h0;
        else age_q <= age_d;
    end
    assign ok = age_q >= 2'h2;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    a_wait_entry: assert property (ok && mode_q == 2'h0 && wait_exec && !stop_exec
        && !dbg_cmd_valid |=> mode_q == 2'h2 && !cpu_clk_en_q && imask_clear_q)
        else $error("wait entry wrong");
    a_stop_entry: assert property (ok && mode_q == 2'h0 && stop_exec && halt_allow_bit
        && !wait_exec && !dbg_cmd_valid |=> mode_q == 2'h3) else $error("stop entry wrong");
    a_stop_refuse: assert property (ok && mode_q == 2'h0 && stop_exec && !halt_allow_bit
        && !dbg_cmd_valid |=> stop_refused_q && mode_q == 2'h0) else $error("stop not refused");
    a_stop_clocks: assert property (ok && mode_q == 2'h3 |-> !cpu_clk_en_q && !bus_clk_en_q)
        else $error("clocks run in stop");
    a_run_guard: assert property (ok && mode_q == 2'h0 && dbg_cmd_valid && dbg_cmd >= 3'h4
        |=> dbg_ignore_q && !dbg_exec_q) else $error("active command ran in run");
    a_cmd_exec: assert property (ok && dbg_cmd_valid && ((mode_q == 2'h0 && dbg_cmd <= 3'h3)
        || (mode_q == 2'h1 && dbg_cmd != 3'h7)) |=> dbg_exec_q) else $error("command not run");
    a_wait_only: assert property (ok && mode_q == 2'h2 && dbg_cmd_valid && dbg_cmd != 3'h1
        && dbg_cmd != 3'h3 |=> dbg_ignore_q && !dbg_mem_en_q) else $error("wait command ran");
    a_status_err: assert property (ok && mode_q[1] && dbg_cmd_valid && dbg_cmd == 3'h1
        |=> dbg_err_q && !dbg_mem_en_q) else $error("status error missing");
    a_bgnd_wake: assert property (ok && mode_q == 2'h2 && dbg_cmd_valid && dbg_cmd == 3'h3
        |=> mode_q == 2'h1) else $error("background did not wake");
    a_vec_addr: assert property (irq_vec_addr_q == 16'hfffe - {10'h000, irq_vec_num_q, 1'b0})
        else $error("vector address mismatch");
    a_idle_vec: assert property (ok && !irq_pend_q |-> irq_vec_num_q == 5'h1f)
        else $error("idle vector wrong");
    a_timer_req: assert property (ok && count_overflow_flag && count_overflow_irq_en
        |=> irq_pend_q && irq_vec_num_q <= 5'h1a) else $error("timer request lost");
endmodule // pmv_checker

bind pmv_top pmv_checker chk (.*);

//--- testbench/test_power_mode_and_vector_control.sv
`timescale 1ns/1ps
module test_power_mode_and_vector_control;
    logic core_clk, rst_n, debug_mode_pin, wait_exec, stop_exec, halt_allow_bit;
    logic stop_deep_sel, ref_keep_cfg, dbg_cmd_valid, gate_on, spi_a, spi_b;
    logic [2:0] dbg_cmd;
    logic [4:0] src_sel, src_sel2, irq_vec_num_q;
    logic [20:0] flags, enables;
    logic [1:0] mode_q;
    logic [15:0] irq_vec_addr_q;
    logic cpu_clk_en_q, bus_clk_en_q, ref_clk_run_q, stop_deep_q, imask_clear_q, stack_start_q;
    logic stop_refused_q, irq_pend_q, dbg_exec_q, dbg_mem_en_q, dbg_err_q, dbg_ignore_q;
    logic trace_step_q;
    logic count_overflow_flag, realtime_irq_flag, two_wire_irq_flag, conversion_done_flag;
    logic port_b_pin_irq_flag, port_a_pin_irq_flag, tx_buffer_empty_flag, transmit_complete_flag;
    logic quiet_line_flag, rx_full_flag, break_detect_flag, rx_pin_edge_flag, overrun_flag;
    logic noise_flag, framing_err_flag, parity_err_flag, serial_transfer_done_flag;
    logic mode_fault_flag, serial_tx_empty_flag, pwm2_overflow_flag, channel_one_event_flag;
    logic count_overflow_irq_en, realtime_irq_en, two_wire_irq_en, converter_irq_en;
    logic port_b_pin_irq_en, port_a_pin_irq_en, tx_buffer_empty_irq_en, transmit_complete_irq_en;
    logic quiet_line_irq_en, rx_full_irq_en, break_detect_irq_en, rx_pin_edge_irq_en;
    logic overrun_irq_en, noise_irq_en, framing_err_irq_en, parity_err_irq_en, serial_rx_irq_en;
    logic serial_tx_empty_irq_en, pwm2_overflow_irq_en, channel_one_irq_en;
    int mismatches = 0;
    int tests_run = 0;
    localparam logic [4:0] vec_tab [0:20] = '{5'h1a, 5'h19, 5'h18, 5'h17, 5'h15, 5'h14,
        5'h12, 5'h12, 5'h11, 5'h11, 5'h11, 5'h11, 5'h10, 5'h10, 5'h10, 5'h10, 5'h0f, 5'h0f,
        5'h0f, 5'h0e, 5'h0d};

    assign {channel_one_event_flag, pwm2_overflow_flag, serial_tx_empty_flag, mode_fault_flag,
        serial_transfer_done_flag, parity_err_flag, framing_err_flag, noise_flag, overrun_flag,
        rx_pin_edge_flag, break_detect_flag, rx_full_flag, quiet_line_flag, transmit_complete_flag,
        tx_buffer_empty_flag, port_a_pin_irq_flag, port_b_pin_irq_flag, conversion_done_flag,
        two_wire_irq_flag, realtime_irq_flag, count_overflow_flag} = flags;
    assign {channel_one_irq_en, pwm2_overflow_irq_en, serial_tx_empty_irq_en, spi_b, spi_a,
        parity_err_irq_en, framing_err_irq_en, noise_irq_en, overrun_irq_en, rx_pin_edge_irq_en,
        break_detect_irq_en, rx_full_irq_en, quiet_line_irq_en, transmit_complete_irq_en,
        tx_buffer_empty_irq_en, port_a_pin_irq_en, port_b_pin_irq_en, converter_irq_en,
        two_wire_irq_en, realtime_irq_en, count_overflow_irq_en} = enables;
    // Shared enable: gated off when either of its flags is gated off
    assign serial_rx_irq_en = spi_a & spi_b;

    pmv_src_model src (.*);
    pmv_top uut (.*);

    always #10 core_clk = ~core_clk;

    task automatic wrap_up();
        if (mismatches == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic cmp(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Expected pulses packed as exec, memory, error, ignore
    task automatic dbg(input logic [2:0] c, input logic [3:0] exp, input logic [1:0] m);
        @(negedge core_clk);
        dbg_cmd = c;
        dbg_cmd_valid = 1'b1;
        @(negedge core_clk);
        dbg_cmd_valid = 1'b0;
        cmp("dbg pulses", {12'h000, exp},
            {12'h000, dbg_exec_q, dbg_mem_en_q, dbg_err_q, dbg_ignore_q});
        cmp("mode", {14'h0000, m}, {14'h0000, mode_q});
    endtask

    task automatic instr(input logic w, input logic s);
        @(negedge core_clk);
        wait_exec = w;
        stop_exec = s;
        @(negedge core_clk);
        wait_exec = 1'b0;
        stop_exec = 1'b0;
    endtask

    task automatic irq(input logic [4:0] a, input logic [4:0] b, input logic g);
        @(negedge core_clk);
        src_sel = a;
        src_sel2 = b;
        gate_on = g;
        @(negedge core_clk);
    endtask

    initial begin
        #40000;
        mismatches++;
        wrap_up();
    end

    initial begin
        {core_clk, rst_n, wait_exec, stop_exec, halt_allow_bit, dbg_cmd_valid} = 6'h00;
        {stop_deep_sel, ref_keep_cfg, dbg_cmd, src_sel, src_sel2, gate_on} = 16'h0000;
        debug_mode_pin = 1'b1;
        repeat (5) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        cmp("idle vec", 16'hffc0, irq_vec_addr_q);
        cmp("clk en", 16'h0007, {13'h0000, cpu_clk_en_q, bus_clk_en_q, ref_clk_run_q});
        for (int i = 0; i < 8; i++) begin
            if (i != 3) dbg(i[2:0], {i < 3, i < 2, 1'b0, i > 3}, 2'h0);
            if (i == 5) cmp("trace", 16'h0000, {15'h0000, trace_step_q});
        end
        dbg(3'h3, 4'h8, 2'h1);
        for (int i = 0; i < 6; i++) begin
            if (i != 3) dbg(i[2:0], {1'b1, i < 2, 2'h0}, 2'h1);
            if (i == 5) cmp("trace", 16'h0001, {15'h0000, trace_step_q});
        end
        dbg(3'h6, 4'h8, 2'h0);
        instr(1'b1, 1'b0);
        cmp("wait entry", 16'h0009, {12'h000, mode_q, cpu_clk_en_q, imask_clear_q});
        for (int i = 0; i < 7; i++) begin
            if (i != 3) dbg(i[2:0], (i == 1) ? 4'h2 : 4'h1, 2'h2);
        end
        dbg(3'h3, 4'h8, 2'h1);
        dbg(3'h6, 4'h8, 2'h0);
        instr(1'b1, 1'b0);
        irq(5'h01, 5'h00, 1'b1);
        cmp("wait wake", 16'h0007,
            {11'h000, mode_q, cpu_clk_en_q, stack_start_q, irq_pend_q});
        irq(5'h00, 5'h00, 1'b1);
        instr(1'b0, 1'b1);
        cmp("stop refused", 16'h0001, {13'h0000, mode_q, stop_refused_q});
        halt_allow_bit = 1'b1;
        for (int k = 0; k < 2; k++) begin
            stop_deep_sel = k[0];
            ref_keep_cfg = k[0];
            instr(1'b0, 1'b1);
            cmp("stop entry", {10'h000, 2'h3, 2'h0, k[0], k[0]}, {10'h000, mode_q,
                cpu_clk_en_q, bus_clk_en_q, ref_clk_run_q, stop_deep_q});
            dbg(3'h1, 4'h2, 2'h3);
            dbg(3'h3, 4'h1, 2'h3);
            irq(5'h15, 5'h00, 1'b1);
            cmp("stop wake", 16'h0007,
                {12'h000, mode_q, cpu_clk_en_q, bus_clk_en_q, stack_start_q});
            irq(5'h00, 5'h00, 1'b1);
        end
        for (int i = 0; i < 21; i++) begin
            irq(i[4:0] + 5'h01, 5'h00, 1'b1);
            cmp("vector", {10'h000, 1'b1, vec_tab[i]},
                {10'h000, irq_pend_q, irq_vec_num_q});
            cmp("address", 16'hfffe - {10'h000, vec_tab[i], 1'b0}, irq_vec_addr_q);
            irq(i[4:0] + 5'h01, 5'h00, 1'b0);
            cmp("gated", 16'h001f, {10'h000, irq_pend_q, irq_vec_num_q});
        end
        irq(5'h01, 5'h15, 1'b1);
        cmp("priority", 16'h002d, {10'h000, irq_pend_q, irq_vec_num_q});
        irq(5'h07, 5'h0d, 1'b1);
        cmp("priority", 16'h0030, {10'h000, irq_pend_q, irq_vec_num_q});
        irq(5'h00, 5'h00, 1'b1);
        debug_mode_pin = 1'b0;
        rst_n = 1'b0;
        repeat (3) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (3) @(negedge core_clk);
        cmp("strap", 16'h0001, {14'h0000, mode_q});
        wrap_up();
    end
endmodule // test_power_mode_and_vector_control
